// ==== core/adv_regs_pkg.sv ====
/*
 Constants for the advanced register bank of the motion engine: register
 indexes, field positions, reset values and the window scheduling figures.
 Assumes byte-wide registers placed one per aligned APB word.
*/
package adv_regs_pkg;
    localparam int PADDR_W = 10;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS = 8'hF0;
    localparam logic [7:0] IDX_WCFG = 8'hF2;
    localparam logic [7:0] IDX_RATE_HI = 8'hF3;
    localparam logic [7:0] IDX_RATE_LO = 8'hF4;
    localparam logic [7:0] IDX_AVG = 8'hF5;
    localparam logic [7:0] IDX_DEB_TIME = 8'hF6;
    localparam logic [7:0] IDX_DEB_MASK = 8'hF7;
    localparam logic [7:0] IDX_TRS_SENSE = 8'hF8;
    localparam logic [7:0] IDX_NSE_SENSE = 8'hF9;
    localparam logic [7:0] IDX_SMP_HI = 8'hFA;
    localparam logic [7:0] IDX_SMP_LO = 8'hFB;
    localparam logic [7:0] IDX_DC_HI = 8'hFC;
    localparam logic [7:0] IDX_DC_LO = 8'hFD;
    // Fields of adv_status_flags
    localparam int BIT_REFRESH = 4;
    localparam int BIT_NEW = 3;
    localparam int BIT_ORIGIN = 2;
    localparam int BIT_NOISE = 1;
    localparam int BIT_TRANS = 0;
    localparam int FLAGS_W = 5;
    // Fields of adv_window_config, then the width of the sensitivity registers
    localparam int LOCK_LSB = 5;
    localparam int SIZE_LSB = 3;
    localparam int RATE_LSB = 0;
    localparam int SENSE_W = 7;
    // Reset values (hardware reset only; engine init never loads them)
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [FLAGS_W-1:0] RST_FLAGS = 5'h00;
    // Window recalculation every UPD_BASE + UPD_STEP * rate samples
    localparam logic [4:0] UPD_BASE = 5'h04;
    localparam int UPD_STEP_SHIFT = 1;
    localparam logic [4:0] UPD_CNT_RST = 5'h00;
endpackage

// ==== core/sched_if.sv ====
/*
 Carrier between the register bank and its window scheduler.
 Assumes both ends run on mclk.
*/
`timescale 1ns/10ps
interface sched_if;
    logic sample_valid;
    logic restart;
    logic [2:0] update_rate;
    logic recalc;
    modport bank (output sample_valid, output restart, output update_rate, input recalc);
    modport sched (input sample_valid, input restart, input update_rate, output recalc);
endinterface

// ==== core/window_sched.sv ====
/*
 Counts fresh sensor samples and raises a one-cycle recalculation pulse
 once every 4 + 2 * rate samples.
 Assumes a synchronous mclk domain and a one-cycle sample_valid pulse.
*/
`timescale 1ns/10ps
module window_sched
    import adv_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    sched_if.sched sif
);
    logic [4:0] cnt_r, cnt_nxt;
    logic recalc_r, recalc_nxt;
    logic [4:0] period;

    always_comb begin
        period = UPD_BASE + (5'(sif.update_rate) << UPD_STEP_SHIFT);
        cnt_nxt = cnt_r;
        recalc_nxt = 1'b0;
        if (sif.restart) begin
            // History discard also restarts the window phase
            cnt_nxt = UPD_CNT_RST;
        end else if (sif.sample_valid) begin
            if (cnt_r + 5'h01 >= period) begin
                cnt_nxt = UPD_CNT_RST;
                recalc_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= UPD_CNT_RST;
            recalc_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            recalc_r <= recalc_nxt;
        end
    end

    assign sif.recalc = recalc_r;

    // A lowered rate may leave the count above the period until the next sample
    period_bound_a: assert property (@(posedge mclk) disable iff (rst)
        sif.sample_valid && !sif.restart |=>
        cnt_r < period || sif.update_rate != $past(sif.update_rate))
        else $error("sample counter passed the window period");
endmodule

// ==== core/pir_engine_advanced_regs.sv ====
/*
 Advanced configuration and status register bank of the motion engine,
 an APB slave with one byte register per aligned word.
 Assumes the engine core supplies single-cycle event pulses on mclk and
 consumes the configuration fields and fill/clear/recalc pulses.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module pir_engine_advanced_regs
    import adv_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [15:0] sample_in,
    input wire logic [15:0] dc_in,
    input wire logic motion_event,
    input wire logic motion_extended,
    input wire logic noise_event,
    input wire logic transient_event,
    input wire logic engine_init,
    input wire logic rate_valid,
    input wire logic [15:0] rate_in,
    output logic fill_fast,
    output logic fill_normal,
    output logic history_clear,
    output logic limits_recalc,
    output logic [2:0] lock_level,
    output logic [1:0] window_size,
    output logic [7:0] averaging_amount,
    output logic [7:0] debounce_duration,
    output logic [7:0] debounce_run_mask,
    output logic [SENSE_W-1:0] transient_sensitivity,
    output logic [SENSE_W-1:0] noise_sensitivity
);
    logic [FLAGS_W-1:0] flags_r, flags_nxt;
    logic [7:0] wcfg_r, wcfg_nxt;
    logic [7:0] avg_r, avg_nxt;
    logic [7:0] dtime_r, dtime_nxt;
    logic [7:0] dmask_r, dmask_nxt;
    logic [SENSE_W-1:0] tsense_r, tsense_nxt;
    logic [SENSE_W-1:0] nsense_r, nsense_nxt;
    logic [15:0] rate_r, rate_nxt;
    logic [15:0] smp_r, smp_nxt;
    logic [15:0] dc_r, dc_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic fast_r, fast_nxt;
    logic norm_r, norm_nxt;
    logic hist_r, hist_nxt;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic setup;
    logic wr;
    logic mapped;
    logic [7:0] rd_val;
    sched_if sif ();

    assign idx = paddr[PADDR_W-1:2];
    assign wbyte = pwdata[7:0];
    assign setup = psel && !penable;

    // Address decode; reads are sampled in the setup cycle
    always_comb begin
        mapped = (paddr[1:0] == 2'b00);
        rd_val = RST_BYTE;
        if (idx == IDX_FLAGS) begin
            rd_val = {3'b000, flags_r};
        end else if (idx == IDX_WCFG) begin
            rd_val = wcfg_r;
        end else if (idx == IDX_RATE_HI) begin
            rd_val = rate_r[15:8];
        end else if (idx == IDX_RATE_LO) begin
            rd_val = rate_r[7:0];
        end else if (idx == IDX_AVG) begin
            rd_val = avg_r;
        end else if (idx == IDX_DEB_TIME) begin
            rd_val = dtime_r;
        end else if (idx == IDX_DEB_MASK) begin
            rd_val = dmask_r;
        end else if (idx == IDX_TRS_SENSE) begin
            rd_val = {1'b0, tsense_r};
        end else if (idx == IDX_NSE_SENSE) begin
            rd_val = {1'b0, nsense_r};
        end else if (idx == IDX_SMP_HI) begin
            rd_val = smp_r[15:8];
        end else if (idx == IDX_SMP_LO) begin
            rd_val = smp_r[7:0];
        end else if (idx == IDX_DC_HI) begin
            rd_val = dc_r[15:8];
        end else if (idx == IDX_DC_LO) begin
            rd_val = dc_r[7:0];
        end else begin
            mapped = 1'b0;
        end
    end

    // Zero wait states; a write lands at the access edge
    assign wr = psel && penable && pwrite && mapped && pstrb[0];

    always_comb begin
        flags_nxt = flags_r;
        wcfg_nxt = wcfg_r;
        avg_nxt = avg_r;
        dtime_nxt = dtime_r;
        dmask_nxt = dmask_r;
        tsense_nxt = tsense_r;
        nsense_nxt = nsense_r;
        rate_nxt = rate_r;
        smp_nxt = smp_r;
        dc_nxt = dc_r;
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        hist_nxt = 1'b0;
        // Init only chooses the fill method; configuration stays untouched
        fast_nxt = engine_init && flags_r[BIT_REFRESH];
        norm_nxt = engine_init && !flags_r[BIT_REFRESH];
        if (setup) begin
            rdata_nxt = pwrite ? RST_BYTE : rd_val;
            err_nxt = !mapped;
        end
        if (wr) begin
            if (idx == IDX_FLAGS) begin
                // Origin bit is read-only; bits 7-5 are dropped
                flags_nxt[BIT_REFRESH] = wbyte[BIT_REFRESH];
                flags_nxt[BIT_NEW] = wbyte[BIT_NEW];
                flags_nxt[BIT_NOISE] = wbyte[BIT_NOISE];
                flags_nxt[BIT_TRANS] = wbyte[BIT_TRANS];
                hist_nxt = wbyte[BIT_REFRESH];
            end else if (idx == IDX_WCFG) begin
                wcfg_nxt = wbyte;
            end else if (idx == IDX_AVG) begin
                avg_nxt = wbyte;
            end else if (idx == IDX_DEB_TIME) begin
                dtime_nxt = wbyte;
            end else if (idx == IDX_DEB_MASK) begin
                dmask_nxt = wbyte;
            end else if (idx == IDX_TRS_SENSE) begin
                tsense_nxt = wbyte[SENSE_W-1:0];
            end else if (idx == IDX_NSE_SENSE) begin
                nsense_nxt = wbyte[SENSE_W-1:0];
            end
        end
        // Engine sets after software clears so a same-cycle event survives
        if (sample_valid) begin
            flags_nxt[BIT_NEW] = 1'b1;
            smp_nxt = sample_in;
        end
        if (motion_event) begin
            flags_nxt[BIT_ORIGIN] = motion_extended;
        end
        if (noise_event) begin
            flags_nxt[BIT_NOISE] = 1'b1;
        end
        if (transient_event) begin
            flags_nxt[BIT_TRANS] = 1'b1;
        end
        if (rate_valid) begin
            rate_nxt = rate_in;
        end
        if (sif.recalc) begin
            dc_nxt = dc_in;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_r <= RST_FLAGS;
            wcfg_r <= RST_BYTE;
            avg_r <= RST_BYTE;
            dtime_r <= RST_BYTE;
            dmask_r <= RST_BYTE;
            tsense_r <= RST_BYTE[SENSE_W-1:0];
            nsense_r <= RST_BYTE[SENSE_W-1:0];
            rate_r <= RST_WORD;
            smp_r <= RST_WORD;
            dc_r <= RST_WORD;
            rdata_r <= RST_BYTE;
            err_r <= 1'b0;
            fast_r <= 1'b0;
            norm_r <= 1'b0;
            hist_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            wcfg_r <= wcfg_nxt;
            avg_r <= avg_nxt;
            dtime_r <= dtime_nxt;
            dmask_r <= dmask_nxt;
            tsense_r <= tsense_nxt;
            nsense_r <= nsense_nxt;
            rate_r <= rate_nxt;
            smp_r <= smp_nxt;
            dc_r <= dc_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
            fast_r <= fast_nxt;
            norm_r <= norm_nxt;
            hist_r <= hist_nxt;
        end
    end

    // A refresh write and a fast fill both restart the window count
    assign sif.sample_valid = sample_valid;
    assign sif.restart = hist_r || fast_r;
    assign sif.update_rate = wcfg_r[RATE_LSB +: 3];

    window_sched u_sched (
        .mclk(mclk),
        .rst(rst),
        .sif(sif)
    );

    assign prdata = {24'h000000, rdata_r};
    // No wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    // Error shows only in the access phase so an idle bus never sees it
    assign pslverr = psel && penable && err_r;
    assign fill_fast = fast_r;
    assign fill_normal = norm_r;
    assign history_clear = hist_r || fast_r;
    assign limits_recalc = sif.recalc;
    assign lock_level = wcfg_r[LOCK_LSB +: 3];
    assign window_size = wcfg_r[SIZE_LSB +: 2];
    assign averaging_amount = avg_r;
    assign debounce_duration = dtime_r;
    assign debounce_run_mask = dmask_r;
    assign transient_sensitivity = tsense_r;
    assign noise_sensitivity = nsense_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    new_sample_set_a: assert property (sample_valid |=> flags_r[BIT_NEW])
        else $error("new-sample flag not set by a fresh sample");
    origin_follow_a: assert property (motion_event |=>
        flags_r[BIT_ORIGIN] == $past(motion_extended))
        else $error("detection origin does not match the event");
    noise_set_a: assert property (noise_event |=> flags_r[BIT_NOISE])
        else $error("noise flag not set");
    transient_set_a: assert property (transient_event |=> flags_r[BIT_TRANS])
        else $error("transient flag not set");
    reserved_zero_a: assert property (setup && !pwrite && idx == IDX_FLAGS
        && paddr[1:0] == 2'b00 |=> prdata[7:5] == 3'b000 && !err_r)
        else $error("reserved status bits read nonzero");
    fill_choice_a: assert property (engine_init |=>
        fill_fast == $past(flags_r[BIT_REFRESH]) && fill_normal != fill_fast)
        else $error("fill method does not follow refresh bit");
    history_drop_a: assert property (wr && idx == IDX_FLAGS && wbyte[BIT_REFRESH]
        |=> history_clear ##1 (u_sched.cnt_r == UPD_CNT_RST || $past(sample_valid)))
        else $error("refresh did not discard history");
    init_keeps_cfg_a: assert property (engine_init && !wr |=>
        $stable(wcfg_r) && $stable(avg_r) && $stable(dmask_r) && $stable(nsense_r))
        else $error("init altered configuration");
    window_write_a: assert property (wr && idx == IDX_WCFG |=>
        lock_level == $past(wbyte[7:5]) && window_size == $past(wbyte[4:3]))
        else $error("window config fields not stored");
    rate_high_a: assert property (setup && !pwrite && idx == IDX_RATE_HI
        && paddr[1:0] == 2'b00 |=> prdata[7:0] == $past(rate_r[15:8]))
        else $error("processing rate high byte wrong");
    recalc_dc_a: assert property (limits_recalc |=> dc_r == $past(dc_in))
        else $error("dc offset not captured at recalculation");

    // Engine-set flags survive until software writes the bit; origin moves only on a motion event
    new_sample_hold_a: assert property (flags_r[BIT_NEW] && !(wr && idx == IDX_FLAGS)
        |=> flags_r[BIT_NEW])
        else $error("new-sample flag dropped without a write");
    noise_hold_a: assert property (flags_r[BIT_NOISE] && !(wr && idx == IDX_FLAGS)
        |=> flags_r[BIT_NOISE])
        else $error("noise flag dropped without a write");
    transient_hold_a: assert property (flags_r[BIT_TRANS] && !(wr && idx == IDX_FLAGS)
        |=> flags_r[BIT_TRANS])
        else $error("transient flag dropped without a write");
    origin_readonly_a: assert property (!motion_event |=> $stable(flags_r[BIT_ORIGIN]))
        else $error("detection origin moved without a motion event");

    // Init and refresh side effects; update rate field storage
    fill_idle_a: assert property (!engine_init |=> !fill_fast && !fill_normal)
        else $error("fill pulse without engine init");
    history_cause_a: assert property (history_clear |-> fill_fast
        || $past(wr && idx == IDX_FLAGS && wbyte[BIT_REFRESH]))
        else $error("history cleared without a refresh");
    init_keeps_more_a: assert property (engine_init && !wr |=>
        $stable(dtime_r) && $stable(tsense_r) && $stable(flags_r[BIT_REFRESH]))
        else $error("init altered configuration");
    rate_field_a: assert property (wr && idx == IDX_WCFG |=>
        sif.update_rate == $past(wbyte[2:0]))
        else $error("update rate field not stored");

    // Address map of the configuration bytes
    averaging_map_a: assert property (wr && idx == IDX_AVG |=>
        averaging_amount == $past(wbyte) && $stable(dtime_r))
        else $error("averaging amount not stored at its address");
    debounce_map_a: assert property (wr && idx == IDX_DEB_TIME |=>
        debounce_duration == $past(wbyte) && $stable(avg_r))
        else $error("debounce duration not stored at its address");
    run_mask_map_a: assert property (wr && idx == IDX_DEB_MASK |=>
        debounce_run_mask == $past(wbyte) && $stable(tsense_r) && $stable(nsense_r))
        else $error("debounce run mask not stored at its address");
    trs_sense_map_a: assert property (wr && idx == IDX_TRS_SENSE |=>
        transient_sensitivity == $past(wbyte[SENSE_W-1:0]))
        else $error("transient sensitivity not stored at its address");
    nse_sense_map_a: assert property (wr && idx == IDX_NSE_SENSE |=>
        noise_sensitivity == $past(wbyte[SENSE_W-1:0]))
        else $error("noise sensitivity not stored at its address");

    // Read path of the engine-supplied words
    rate_low_a: assert property (setup && !pwrite && idx == IDX_RATE_LO
        && paddr[1:0] == 2'b00 |=> prdata[7:0] == $past(rate_r[7:0]))
        else $error("processing rate low byte wrong");
    sample_capture_a: assert property (sample_valid |=> smp_r == $past(sample_in))
        else $error("sensor sample not captured");
    sample_high_a: assert property (setup && !pwrite && idx == IDX_SMP_HI
        && paddr[1:0] == 2'b00 |=> prdata[7:0] == $past(smp_r[15:8]))
        else $error("sensor sample high byte wrong");
    dc_low_a: assert property (setup && !pwrite && idx == IDX_DC_LO
        && paddr[1:0] == 2'b00 |=> prdata[7:0] == $past(dc_r[7:0]))
        else $error("dc offset low byte wrong");
endmodule

// ==== verif/tb_top.sv ====
/*
 Self-checking bench for the advanced register bank: APB tasks, event
 pulses from the engine side, and counters of the one-cycle outputs.
 Assumes the package constants and a zero-wait APB slave on mclk.
*/
`timescale 1ns/10ps
module tb_top;
    import adv_regs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h1;
    logic [31:0] prdata;
    logic pready, pslverr, fill_fast, fill_normal, history_clear, limits_recalc;
    logic [5:0] ev = 6'h00;
    logic motion_extended = 1'b0;
    logic [15:0] sample_in = 16'hC3E1;
    logic [15:0] dc_in = 16'h5A3C;
    logic [15:0] rate_in = 16'hABCD;
    logic [2:0] lock_level;
    logic [1:0] window_size;
    logic [7:0] averaging_amount, debounce_duration, debounce_run_mask;
    logic [SENSE_W-1:0] transient_sensitivity, noise_sensitivity;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int comparisons = 0;
    int n_fast = 0, n_norm = 0, n_hist = 0, n_recalc = 0, base;

    always #4 mclk = ~mclk;

    // Event lines: 0 sample, 1 motion, 2 noise, 3 transient, 4 init, 5 rate
    pir_engine_advanced_regs u_pir_engine_advanced_regs (.mclk(mclk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(ev[0]), .sample_in(sample_in), .dc_in(dc_in), .motion_event(ev[1]),
        .motion_extended(motion_extended), .noise_event(ev[2]), .transient_event(ev[3]),
        .engine_init(ev[4]), .rate_valid(ev[5]), .rate_in(rate_in), .fill_fast(fill_fast),
        .fill_normal(fill_normal), .history_clear(history_clear),
        .limits_recalc(limits_recalc), .lock_level(lock_level), .window_size(window_size),
        .averaging_amount(averaging_amount), .debounce_duration(debounce_duration),
        .debounce_run_mask(debounce_run_mask), .transient_sensitivity(transient_sensitivity),
        .noise_sensitivity(noise_sensitivity));

    // Pulses are counted, so a stuck-high output shows up as an excess count
    always @(posedge mclk) begin
        if (fill_fast === 1'b1) n_fast++;
        if (fill_normal === 1'b1) n_norm++;
        if (history_clear === 1'b1) n_hist++;
        if (limits_recalc === 1'b1) n_recalc++;
    end

    task automatic print_verdict;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input string name);
        apb(1'b0, idx, 8'h00);
        check(name, {24'h0, exp}, rd);
    endtask

    task automatic pulse(input int b);
        @(posedge mclk);
        ev <= 6'(1 << b);
        @(posedge mclk);
        ev <= 6'h00;
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rchk(IDX_FLAGS, 8'h00, "flags_reset");
        for (int s = 0; s < 4; s++) begin
            wr(IDX_WCFG, {3'h2, 2'(s), 3'h1});
            check("window_size", 32'(s), 32'(window_size));
        end
        check("lock_level", 32'h2, 32'(lock_level));
        for (int i = 0; i < 5; i++) wr(IDX_AVG + 8'(i), 8'h81 + 8'(i));
        pstrb <= 4'h0;
        wr(IDX_AVG, 8'h11);
        pstrb <= 4'h1;
        pulse(4);
        idle(3);
        check("fill_normal", 32'h1, 32'(n_norm));
        check("fill_fast", 32'h0, 32'(n_fast));
        rchk(IDX_WCFG, 8'h59, "wcfg_after_init");
        for (int i = 0; i < 5; i++) begin
            rchk(IDX_AVG + 8'(i), 8'(i) + ((i < 3) ? 8'h81 : 8'h01), "cfg");
        end
        check("avg_out", 32'h81, 32'(averaging_amount));
        check("deb_out", 32'h82, 32'(debounce_duration));
        check("mask_out", 32'h83, 32'(debounce_run_mask));
        check("trs_out", 32'h04, 32'(transient_sensitivity));
        check("nse_out", 32'h05, 32'(noise_sensitivity));
        apb(1'b0, 8'hF1, 8'h00);
        check("unmapped_err", 32'h1, 32'(er));
        wr(IDX_FLAGS, 8'h10);
        idle(2);
        check("history_clear", 32'h1, 32'(n_hist));
        rchk(IDX_FLAGS, 8'h10, "refresh_bit");
        pulse(4);
        idle(3);
        check("fill_fast", 32'h1, 32'(n_fast));
        check("clear_on_init", 32'h2, 32'(n_hist));
        wr(IDX_FLAGS, 8'hE0);
        rchk(IDX_FLAGS, 8'h00, "reserved");
        for (int r = 0; r < 8; r += 7) begin
            wr(IDX_WCFG, {3'h2, 2'h3, 3'(r)});
            wr(IDX_FLAGS, 8'h10);
            wr(IDX_FLAGS, 8'h00);
            base = n_recalc;
            repeat (3 + 2 * r) pulse(0);
            idle(3);
            check("early_recalc", 32'(base), 32'(n_recalc));
            pulse(0);
            idle(3);
            check("recalc", 32'(base + 1), 32'(n_recalc));
        end
        rchk(IDX_DC_HI, 8'h5A, "dc_hi");
        rchk(IDX_DC_LO, 8'h3C, "dc_lo");
        rchk(IDX_SMP_HI, 8'hC3, "smp_hi");
        rchk(IDX_SMP_LO, 8'hE1, "smp_lo");
        rchk(IDX_FLAGS, 8'h08, "new_sample");
        wr(IDX_FLAGS, 8'h00);
        pulse(2);
        rchk(IDX_FLAGS, 8'h02, "noise");
        pulse(3);
        rchk(IDX_FLAGS, 8'h03, "transient");
        motion_extended <= 1'b1;
        pulse(1);
        rchk(IDX_FLAGS, 8'h07, "origin_ext");
        wr(IDX_FLAGS, 8'h00);
        rchk(IDX_FLAGS, 8'h04, "origin_ro");
        motion_extended <= 1'b0;
        pulse(1);
        rchk(IDX_FLAGS, 8'h00, "origin_norm");
        pulse(5);
        rchk(IDX_RATE_HI, 8'hAB, "rate_hi");
        rchk(IDX_RATE_LO, 8'hCD, "rate_lo");
        print_verdict();
    end

    // The sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end
endmodule
